// [rail_power_up_sequencer_tb.sv]
// self-checking bench for the rail power-up sequencer
`timescale 1ns/1ps
`default_nettype none
module rail_power_up_sequencer_tb;
	import rps_pkg::*;
	logic        clk, reset, seq_req, hw_en, gpio, unl, t_rm, u_rm, lock_req, ack;
	logic        supply, input_undervoltage_lockout, live, tog, rld_seen, prev_int, rq_en, v_clr;
	logic        use_def, rld, int_n, rst_n, resid, sfault, err;
	logic [3:0]  asg, never, stuck, en, dis, pg, above, frail, rq_sel, viol;
	logic [11:0] slots;
	logic [23:0] idly, sdly, swait, dwait;
	logic [15:0] st, prev_st;
	logic [2:0]  cnt, prev_cnt;
	logic [31:0] seed;
	int          fail_count, cmp_count;

	rps_sequencer #(.INIT_TIMEOUT(24'h000014)) rps_sequencer_inst (
		.CLK(clk), .RESET(reset), .SEQ_REQUEST(seq_req), .RAIL_ENABLE_REQ(rq_en),
		.RAIL_ENABLE_SEL(rq_sel), .UNLOCK_REQUEST_BIT(unl), .THERMAL_REARM_BIT(t_rm),
		.UNDERVOLTAGE_REARM_BIT(u_rm), .VIOLATION_CLEAR(v_clr), .LOCK_REQUEST(lock_req),
		.HW_ENABLE_GPIO_CFG(gpio), .RAIL_SLOT(slots), .RAIL_ASSIGNED(asg), .INIT_DELAY(idly),
		.SLOT_DELAY(sdly), .SLOT_WAIT(swait), .SLOT_TIMEOUT(24'h00001E), .DONE_WAIT(dwait),
		.DEFAULTS_RELOAD_ACK(ack), .MAIN_INPUT_SUPPLY_OK(supply), .HARDWARE_ENABLE_INPUT(hw_en),
		.INPUT_UNDERVOLTAGE_LOCKOUT(input_undervoltage_lockout), .THERMAL_SHUTDOWN(1'b0), .RAIL_POWER_GOOD(pg),
		.RAIL_ABOVE_DISABLE(above), .LIVE_INTERRUPT(live), .RAIL_ENABLE(en),
		.RAIL_DISCHARGE(dis), .USE_DEFAULT_VOLTAGE(use_def), .RELOAD_DEFAULTS(rld),
		.INTERRUPT_OUT_N(int_n), .SYSTEM_RESET_OUT_N(rst_n), .SEQ_STATE(st), .SLOT_COUNT(cnt),
		.RESIDUAL_FAULT(resid), .SEQ_FAULT(sfault), .FAULT_RAIL(frail),
		.ENABLE_VIOLATION(viol), .ERROR_PD(err));

	rps_rail_model rps_rail_model_inst (.clk(clk), .reset(reset), .rail_enable(en),
		.rail_discharge(dis), .never_up(never), .stuck_high(stuck), .power_good(pg),
		.above_disable(above));

	////////////////////////////////////////////////////////////////////////////////
	initial clk = 1'b0;
	always #20 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_st(input rps_state_t s, input int lim);
		int n;
		n = 0;
		while (st !== s && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("state", s, st);
	endtask

	task give_verdict();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// frozen outputs and slot counter steps during the sequence
	always @(negedge clk) begin
		if (!reset && |st[10:2]) begin
			chk("reset_out", 1'b0, rst_n);
			if (|prev_st[10:2]) chk("int_out", prev_int, int_n);
			if (|prev_st[10:3] && !st[3] && cnt !== prev_cnt) chk("slot", prev_cnt + 3'h1, cnt);
		end
		if (rld === 1'b1) rld_seen = 1'b1;
		if (tog) live <= ~live;
		prev_st = st;
		prev_int = int_n;
		prev_cnt = cnt;
	end

	task automatic run(input logic [3:0] a, input logic [11:0] sl, input logic [3:0] f,
			input logic [3:0] sk, input int uv, input int mode);
		seed = xs(seed);
		asg = a;
		slots = sl;
		never = f;
		stuck = sk;
		idly = {20'h0, seed[3:0]};
		sdly = {20'h0, seed[7:4]};
		swait = {20'h0, seed[11:8]};
		dwait = {20'h0, seed[15:12]};
		tog = 1'b1;
		supply = (mode != 2);
		hw_en = 1'b0;
		@(negedge clk);
		case (mode)
			0: seq_req = 1'b1;
			1: hw_en = 1'b1;
			default: supply = 1'b1;
		endcase
		wait_st(ST_PU_INIT, 4);
		chk("discharge", a, dis);
		seq_req = 1'b0;
		if (sk != 4'h0) begin
			wait_st(ST_FAULT, 40);
			chk("residual", 1'b1, resid);
		end else begin
			wait_st(ST_S0_INIT, 30);
			chk("slot0", 3'h0, cnt);
			if (uv != 0) begin
				wait_st(ST_SOFT, 60);
				input_undervoltage_lockout = 1'b1;
				wait_st((uv == 1) ? ST_HIC_CHECK : ST_ERROR, 4);
				repeat (4) @(negedge clk);
				input_undervoltage_lockout = 1'b0;
				if (uv == 1) wait_st(ST_HIC_RESTART, 4);
				else chk("error_pd", 1'b1, err);
			end
			if (f != 4'h0) begin
				wait_st(ST_FAULT, 1000);
				@(negedge clk);
				chk("seq_fault", 1'b1, sfault);
				chk("fault_rail", f, frail);
			end else if (uv != 2) begin
				wait_st(ST_ACTIVE, 1000);
				chk("enables", a, en);
				chk("reset_rel", 1'b1, rst_n);
				tog = 1'b0;
				@(negedge clk);
				live = 1'b1;
				repeat (3) @(negedge clk);
				chk("int_live", 1'b0, int_n);
				never = a & (~a + 4'h1);
				rq_sel = 4'hF;
				rq_en = 1'b1;
				@(negedge clk);
				rq_en = 1'b0;
				repeat (20) @(negedge clk);
				chk("viol_early", 4'h0, viol);
				repeat (13) @(negedge clk);
				chk("violation", a & (~a + 4'h1), viol);
				v_clr = 1'b1;
				@(negedge clk);
				v_clr = 1'b0;
				chk("viol_clear", 4'h0, viol);
				never = 4'h0;
				lock_req = 1'b1;
				@(negedge clk);
				lock_req = 1'b0;
			end
		end
		wait_st(ST_LOCK, 4);
		chk("lock_en", 4'h0, en);
		chk("lock_int", 1'b0, int_n);
		chk("lock_rst", 1'b0, rst_n);
		seq_req = 1'b1;
		repeat (3) @(negedge clk);
		chk("locked", ST_LOCK, st);
		seq_req = 1'b0;
		rld_seen = 1'b0;
		case (mode)
			0: unl = 1'b1;
			1: t_rm = 1'b1;
			default: u_rm = 1'b1;
		endcase
		wait_st(ST_OFF, 4);
		@(negedge clk);
		chk("reload", 1'b1, rld_seen);
		unl = 1'b0;
		t_rm = 1'b0;
		u_rm = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{seq_req, hw_en, unl, t_rm, u_rm, lock_req, ack, input_undervoltage_lockout, live, tog, rq_en, v_clr} = 12'h000;
		{gpio, supply, reset} = 3'h5;
		{asg, never, stuck, rq_sel, slots} = 28'h0000000;
		{idly, sdly, swait, dwait} = 96'h0;
		fail_count = 0;
		cmp_count = 0;
		seed = 32'hB37E;
		repeat (6) @(negedge clk);
		reset = 1'b0;
		chk("rst_state", ST_OFF, st);
		chk("rst_int", 1'b1, int_n);
		ack = 1'b1;
		@(negedge clk);
		chk("use_def", 1'b0, use_def);
		ack = 1'b0;
		@(negedge clk);
		chk("use_def", 1'b1, use_def);
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			run((seed[3:0] == 4'h0) ? 4'h4 : seed[3:0], seed[27:16], 4'h0, 4'h0, 0, (i + 2) % 3);
		end
		run(4'h6, 12'h048, 4'h2, 4'h0, 0, 0);
		run(4'h5, 12'h000, 4'h0, 4'h4, 0, 1);
		run(4'h1, 12'h000, 4'h0, 4'h0, 1, 2);
		run(4'h3, 12'h000, 4'h0, 4'h0, 2, 0);
		give_verdict();
	end

	initial begin
		#(40 * 40000);
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire

// [rps_pkg.sv]
// constants and types for the rail power-up sequencer
package rps_pkg;
	localparam int NUM_RAILS = 4;
	localparam int NUM_SLOTS = 8;
	localparam int SLOT_W    = 3;
	localparam int CLK_MHZ   = 25;
	localparam int INIT_TIMEOUT_MS = 64;
	localparam int INIT_TIMEOUT_CYC = INIT_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int TMR_W     = 24;
	localparam int COAX_RAIL = 0;
	localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_STEP  = 3'h1;
	localparam logic [SLOT_W-1:0] SLOT_LAST  = 3'h7;
	localparam logic [TMR_W-1:0]  TMR_ZERO   = 24'h000000;
	localparam logic [TMR_W-1:0]  TMR_ONE    = 24'h000001;

	typedef enum logic [15:0] {
		ST_OFF       = 16'h0001,
		ST_LOCK      = 16'h0002,
		ST_PU_INIT   = 16'h0004,
		ST_S0_INIT   = 16'h0008,
		ST_SX_INIT   = 16'h0010,
		ST_DELAY     = 16'h0020,
		ST_WAIT      = 16'h0040,
		ST_SOFT      = 16'h0080,
		ST_HIC_CHECK = 16'h0100,
		ST_HIC_RESTART = 16'h0200,
		ST_SLOT_END  = 16'h0400,
		ST_ALLOW_INT = 16'h0800,
		ST_ALLOW_RST = 16'h1000,
		ST_ACTIVE    = 16'h2000,
		ST_FAULT     = 16'h4000,
		ST_ERROR     = 16'h8000
	} rps_state_t;
endpackage

// [rps_rail_model.sv]
// rail and monitor model standing at the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module rps_rail_model
	import rps_pkg::*;
#(
	parameter int PG_DLY = 8
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// regulator controls
	input  wire logic [NUM_RAILS-1:0] rail_enable,
	input  wire logic [NUM_RAILS-1:0] rail_discharge,
	// fault injection
	input  wire logic [NUM_RAILS-1:0] never_up,
	input  wire logic [NUM_RAILS-1:0] stuck_high,
	// monitors
	output logic      [NUM_RAILS-1:0] power_good,
	output logic      [NUM_RAILS-1:0] above_disable
);
	int ramp [NUM_RAILS];

	always @(posedge clk or posedge reset) begin
		for (int i = 0; i < NUM_RAILS; i++) begin
			if (reset || !rail_enable[i]) begin
				ramp[i] <= 0;
			end else if (ramp[i] < PG_DLY) begin
				ramp[i] <= ramp[i] + 1;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_RAILS; i++) begin
			power_good[i]    = (ramp[i] >= PG_DLY) && !never_up[i];
			above_disable[i] = (ramp[i] > 0 && !rail_discharge[i]) || stuck_high[i];
		end
	end
endmodule
`default_nettype wire

// [rps_sequencer.sv]
// power-up sequencer with lock and hiccup recovery
//
// What this block does
// - in lock, all rails off, interrupt and reset outputs low
// - while locked, requests are accepted but no sequence starts
// - lock left only by unlock bit or matching rearm bit
// - unlock goes to initial state; reloads defaults except error flag sets
// - sequence starts on supply application or host request; config overridable
// - a started sequence aborts only on fault or error
// - init enables discharge, 64 ms timeout, residual voltage blocks start
// - interrupt output frozen and reset held low during the sequence
// - first slot init sets counter 0, stops discharge of its rails
// - first slot delay starts the initial delay timer
// - wait state starts slot wait timer; slots follow previous success
// - soft start starts slot timeout and ramps assigned rails
// - rail counts as up only when debounced above undervoltage level
// - slot timeout is a sequence fault, logged with offending rail
// - host-enabled assigned rail checked against timeout, violation clearable
// - rails come up at default voltage unless host overwrote it
// - supply lockout during coax ramp in slot 0 enters hiccup check
// - hiccup restart resumes soft start, timer keeps running
// - no hiccup recovery in any other configuration
// - later slot init increments counter, stops discharge of its rails
// - slot end checks for remaining assigned rails
// - after slots unfreeze interrupt, run done wait, release reset
// - hiccup timeout goes to error power-down
// - off state starts on host request, supply rise or enable input rise
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer
	import rps_pkg::*;
#(
	parameter logic [TMR_W-1:0] INIT_TIMEOUT = TMR_W'(INIT_TIMEOUT_CYC)
) (
	// clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RESET,
	// host control
	input  wire logic                 SEQ_REQUEST,
	input  wire logic                 RAIL_ENABLE_REQ,
	input  wire logic [NUM_RAILS-1:0] RAIL_ENABLE_SEL,
	input  wire logic                 UNLOCK_REQUEST_BIT,
	input  wire logic                 THERMAL_REARM_BIT,
	input  wire logic                 UNDERVOLTAGE_REARM_BIT,
	input  wire logic                 VIOLATION_CLEAR,
	input  wire logic                 LOCK_REQUEST,
	input  wire logic                 HW_ENABLE_GPIO_CFG,
	// configuration
	input  wire logic [NUM_RAILS*SLOT_W-1:0] RAIL_SLOT,
	input  wire logic [NUM_RAILS-1:0] RAIL_ASSIGNED,
	input  wire logic [TMR_W-1:0]     INIT_DELAY,
	input  wire logic [TMR_W-1:0]     SLOT_DELAY,
	input  wire logic [TMR_W-1:0]     SLOT_WAIT,
	input  wire logic [TMR_W-1:0]     SLOT_TIMEOUT,
	input  wire logic [TMR_W-1:0]     DONE_WAIT,
	input  wire logic                 DEFAULTS_RELOAD_ACK,
	// monitors
	input  wire logic                 MAIN_INPUT_SUPPLY_OK,
	input  wire logic                 HARDWARE_ENABLE_INPUT,
	input  wire logic                 INPUT_UNDERVOLTAGE_LOCKOUT,
	input  wire logic                 THERMAL_SHUTDOWN,
	input  wire logic [NUM_RAILS-1:0] RAIL_POWER_GOOD,
	input  wire logic [NUM_RAILS-1:0] RAIL_ABOVE_DISABLE,
	input  wire logic                 LIVE_INTERRUPT,
	// regulator controls
	output logic [NUM_RAILS-1:0]      RAIL_ENABLE,
	output logic [NUM_RAILS-1:0]      RAIL_DISCHARGE,
	output logic                      USE_DEFAULT_VOLTAGE,
	output logic                      RELOAD_DEFAULTS,
	// pins
	output logic                      INTERRUPT_OUT_N,
	output logic                      SYSTEM_RESET_OUT_N,
	// status
	output logic [15:0]               SEQ_STATE,
	output logic [SLOT_W-1:0]         SLOT_COUNT,
	output logic                      RESIDUAL_FAULT,
	output logic                      SEQ_FAULT,
	output logic [NUM_RAILS-1:0]      FAULT_RAIL,
	output logic [NUM_RAILS-1:0]      ENABLE_VIOLATION,
	output logic                      ERROR_PD
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		rps_state_t             st;
		logic [SLOT_W-1:0]      slot;
		logic [TMR_W-1:0]       tmr;
		logic [TMR_W-1:0]       slot_tmr;
		logic [NUM_RAILS-1:0]   en;
		logic [NUM_RAILS-1:0]   dis;
		logic                   int_frozen;
		logic                   int_n;
		logic                   rst_n;
		logic                   hardware_enable_input_prev;
		logic                   supply_prev;
		logic                   res_fault;
		logic                   seq_fault;
		logic [NUM_RAILS-1:0]   fault_rail;
		logic [NUM_RAILS-1:0]   viol;
		logic [NUM_RAILS-1:0]   chk;
		logic [TMR_W-1:0]       chk_tmr;
		logic                   err;
		logic                   reload;
	} rps_regs_t;

	rps_regs_t r_r;
	rps_regs_t r_nxt;

	////////////////////////////////////////////////////////////////////////////
	logic [NUM_RAILS-1:0] in_slot;
	logic [NUM_RAILS-1:0] later_slot;
	logic [NUM_RAILS-1:0] slot0_rails;

	genvar g;
	generate
		for (g = 0; g < NUM_RAILS; g++) begin : g_rail
			assign in_slot[g]     = RAIL_ASSIGNED[g] && RAIL_SLOT[g*SLOT_W +: SLOT_W] == r_r.slot;
			assign later_slot[g]  = RAIL_ASSIGNED[g] && RAIL_SLOT[g*SLOT_W +: SLOT_W] > r_r.slot;
			assign slot0_rails[g] = RAIL_ASSIGNED[g] && RAIL_SLOT[g*SLOT_W +: SLOT_W] == SLOT_FIRST;
		end
	endgenerate

	logic slot_up;
	logic hiccup_ok;
	logic unlock;
	logic start_req;
	assign slot_up   = (in_slot & RAIL_POWER_GOOD) == in_slot;
	assign hiccup_ok = r_r.slot == SLOT_FIRST && slot0_rails == (NUM_RAILS'(1) << COAX_RAIL)
		&& RAIL_ENABLE[COAX_RAIL];
	assign unlock = UNLOCK_REQUEST_BIT || (THERMAL_REARM_BIT && !THERMAL_SHUTDOWN)
		|| (UNDERVOLTAGE_REARM_BIT && !INPUT_UNDERVOLTAGE_LOCKOUT);
	assign start_req = SEQ_REQUEST || (MAIN_INPUT_SUPPLY_OK && !r_r.supply_prev)
		|| (HW_ENABLE_GPIO_CFG && HARDWARE_ENABLE_INPUT && !r_r.hardware_enable_input_prev);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_nxt             = r_r;
		r_nxt.reload      = 1'b0;
		r_nxt.hardware_enable_input_prev   = HARDWARE_ENABLE_INPUT;
		r_nxt.supply_prev = MAIN_INPUT_SUPPLY_OK;
		if (r_r.tmr != TMR_ZERO) begin
			r_nxt.tmr = r_r.tmr - TMR_ONE;
		end
		if (r_r.slot_tmr != TMR_ZERO) begin
			r_nxt.slot_tmr = r_r.slot_tmr - TMR_ONE;
		end
		if (!r_r.int_frozen) begin
			r_nxt.int_n = !LIVE_INTERRUPT;
		end
		// host enable check during operation
		if (r_r.st == ST_ACTIVE && RAIL_ENABLE_REQ) begin
			r_nxt.en      = r_r.en | RAIL_ENABLE_SEL;
			r_nxt.chk     = r_r.chk | (RAIL_ENABLE_SEL & RAIL_ASSIGNED);
			r_nxt.chk_tmr = SLOT_TIMEOUT;
		end else if (r_r.chk != '0) begin
			r_nxt.chk = r_r.chk & ~RAIL_POWER_GOOD;
			if (r_r.chk_tmr == TMR_ZERO) begin
				r_nxt.chk = '0;
			end else begin
				r_nxt.chk_tmr = r_r.chk_tmr - TMR_ONE;
			end
		end
		if (VIOLATION_CLEAR) begin
			r_nxt.viol = '0;
		end
		if (r_r.chk != '0 && r_r.chk_tmr == TMR_ZERO) begin
			r_nxt.viol = r_r.viol | (r_r.chk & ~RAIL_POWER_GOOD);
		end
		unique case (r_r.st)
			ST_OFF: begin
				if (start_req) begin
					r_nxt.st         = ST_PU_INIT;
					r_nxt.tmr        = INIT_TIMEOUT;
					r_nxt.dis        = RAIL_ASSIGNED;
					r_nxt.int_frozen = 1'b1;
					r_nxt.rst_n      = 1'b0;
					r_nxt.res_fault  = 1'b0;
				end
			end
			ST_LOCK: begin
				r_nxt.en    = '0;
				r_nxt.int_n = 1'b0;
				r_nxt.rst_n = 1'b0;
				if (unlock) begin
					r_nxt.st         = ST_OFF;
					r_nxt.reload     = 1'b1;
					r_nxt.int_frozen = 1'b0;
					r_nxt.seq_fault  = 1'b0;
					r_nxt.err        = 1'b0;
					r_nxt.dis        = '0;
				end
			end
			ST_PU_INIT: begin
				if (r_r.tmr == TMR_ZERO) begin
					if ((RAIL_ABOVE_DISABLE & RAIL_ASSIGNED) != '0) begin
						r_nxt.res_fault = 1'b1;
						r_nxt.st        = ST_FAULT;
					end else begin
						r_nxt.st   = ST_S0_INIT;
						r_nxt.slot = SLOT_FIRST;
					end
				end
			end
			ST_S0_INIT: begin
				r_nxt.slot = SLOT_FIRST;
				r_nxt.dis  = r_r.dis & ~slot0_rails;
				r_nxt.tmr  = INIT_DELAY;
				r_nxt.st   = ST_DELAY;
			end
			ST_SX_INIT: begin
				r_nxt.dis = r_r.dis & ~in_slot;
				r_nxt.tmr = SLOT_DELAY;
				r_nxt.st  = ST_DELAY;
			end
			ST_DELAY: begin
				if (r_r.tmr == TMR_ZERO) begin
					if (in_slot != '0) begin
						r_nxt.st       = ST_SOFT;
						r_nxt.slot_tmr = SLOT_TIMEOUT;
						r_nxt.en       = r_r.en | in_slot;
					end else begin
						r_nxt.st  = ST_WAIT;
						r_nxt.tmr = SLOT_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (r_r.tmr == TMR_ZERO) begin
					r_nxt.st = ST_SLOT_END;
				end
			end
			ST_SOFT, ST_HIC_RESTART: begin
				if (INPUT_UNDERVOLTAGE_LOCKOUT) begin
					if (hiccup_ok) begin
						r_nxt.st = ST_HIC_CHECK;
						r_nxt.en = r_r.en & ~in_slot;
					end else begin
						r_nxt.st  = ST_ERROR;
						r_nxt.err = 1'b1;
					end
				end else if (slot_up) begin
					r_nxt.st = ST_SLOT_END;
				end else if (r_r.slot_tmr == TMR_ZERO) begin
					if (r_r.st == ST_HIC_RESTART) begin
						r_nxt.st  = ST_ERROR;
						r_nxt.err = 1'b1;
					end else begin
						r_nxt.st         = ST_FAULT;
						r_nxt.seq_fault  = 1'b1;
						r_nxt.fault_rail = in_slot & ~RAIL_POWER_GOOD;
					end
				end
			end
			ST_HIC_CHECK: begin
				if (r_r.slot_tmr == TMR_ZERO) begin
					r_nxt.st  = ST_ERROR;
					r_nxt.err = 1'b1;
				end else if (!INPUT_UNDERVOLTAGE_LOCKOUT) begin
					r_nxt.st = ST_HIC_RESTART;
					r_nxt.en = r_r.en | in_slot;
				end
			end
			ST_SLOT_END: begin
				if (later_slot != '0 && r_r.slot != SLOT_LAST) begin
					r_nxt.slot = r_r.slot + SLOT_STEP;
					r_nxt.st   = ST_SX_INIT;
				end else begin
					r_nxt.st         = ST_ALLOW_INT;
					r_nxt.int_frozen = 1'b0;
					r_nxt.tmr        = DONE_WAIT;
				end
			end
			ST_ALLOW_INT: begin
				if (r_r.tmr == TMR_ZERO) begin
					r_nxt.st = ST_ALLOW_RST;
				end
			end
			ST_ALLOW_RST: begin
				r_nxt.rst_n = 1'b1;
				r_nxt.st    = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (LOCK_REQUEST) begin
					r_nxt.st = ST_LOCK;
				end
			end
			ST_FAULT, ST_ERROR: begin
				r_nxt.en    = '0;
				r_nxt.dis   = RAIL_ASSIGNED;
				r_nxt.rst_n = 1'b0;
				r_nxt.st    = ST_LOCK;
			end
			default: begin
				r_nxt.st = ST_LOCK;
			end
		endcase
		if (LOCK_REQUEST && r_r.st == ST_OFF) begin
			r_nxt.st = ST_LOCK;
		end
		if (r_nxt.st == ST_LOCK) begin
			r_nxt.en    = '0;
			r_nxt.int_n = 1'b0;
			r_nxt.rst_n = 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			r_r            <= '0;
			r_r.st         <= ST_OFF;
			r_r.int_n      <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign RAIL_ENABLE         = r_r.en;
	assign RAIL_DISCHARGE      = r_r.dis;
	assign USE_DEFAULT_VOLTAGE = !DEFAULTS_RELOAD_ACK;
	assign RELOAD_DEFAULTS     = r_r.reload;
	assign INTERRUPT_OUT_N     = r_r.int_n;
	assign SYSTEM_RESET_OUT_N  = r_r.rst_n;
	assign SEQ_STATE           = r_r.st;
	assign SLOT_COUNT          = r_r.slot;
	assign RESIDUAL_FAULT      = r_r.res_fault;
	assign SEQ_FAULT           = r_r.seq_fault;
	assign FAULT_RAIL          = r_r.fault_rail;
	assign ENABLE_VIOLATION    = r_r.viol;
	assign ERROR_PD            = r_r.err;

	////////////////////////////////////////////////////////////////////////////
	lock_outputs_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_LOCK |=> !SYSTEM_RESET_OUT_N && !INTERRUPT_OUT_N)
		else $error("lock outputs not low");
	lock_hold_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_LOCK && !unlock |=> r_r.st == ST_LOCK)
		else $error("sequence left lock without unlock");
	unlock_reload_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_LOCK && unlock |=> RELOAD_DEFAULTS && r_r.st == ST_OFF)
		else $error("unlock did not reload");
	init_dis_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_OFF && start_req |=> RAIL_DISCHARGE == RAIL_ASSIGNED)
		else $error("init discharge missing");
	seq_rst_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_PU_INIT |-> !SYSTEM_RESET_OUT_N && r_r.int_frozen)
		else $error("reset not held in sequence");
	slot0_zero_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_S0_INIT |=> SLOT_COUNT == 3'h0 ##0 r_r.st == ST_DELAY)
		else $error("slot counter not zeroed");
	slot_inc_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_SLOT_END && later_slot != '0 && r_r.slot != SLOT_LAST
		|=> SLOT_COUNT == $past(SLOT_COUNT) + 3'h1)
		else $error("slot counter not advanced");
	hiccup_only_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_SOFT && INPUT_UNDERVOLTAGE_LOCKOUT && !hiccup_ok |=> r_r.st == ST_ERROR)
		else $error("hiccup entered in wrong configuration");
	rst_release_a: assert property (@(posedge CLK) disable iff (RESET)
		r_r.st == ST_ALLOW_RST |=> SYSTEM_RESET_OUT_N ##1 SYSTEM_RESET_OUT_N || r_r.st != ST_ACTIVE)
		else $error("reset not released");
endmodule
`default_nettype wire
